/* include/spbsf_defs.svh */
// Offsets, field positions and reset values of the serial port status flag block.
// Assumes one 32-bit APB word per register, decoded on paddr[7:0].
`ifndef SPBSF_DEFS_SVH
`define SPBSF_DEFS_SVH
`define SPBSF_OFS_STATUS 8'h00
`define SPBSF_OFS_CTRL 8'h04
`define SPBSF_OFS_DATA 8'h08
`define SPBSF_OFS_ISTAT 8'h0C
`define SPBSF_OFS_IMASK 8'h10
`define SPBSF_BIT_CTRL_FIFO 0
`define SPBSF_INT_W 3
`define SPBSF_RST_INT 3'h0
`define SPBSF_RST_FLAGS 4'h8
`endif

/* include/spbsf_pkg.sv */
// Types shared by the serial port status flag block and its bench.
// Assumes the includer compiles this before any design file.
package spbsf_pkg;
   // Low nibble of the status word, bit 3 down to bit 0.
   typedef struct packed {
      logic txEmpty;
      logic unused;
      logic txFull;
      logic rxFull;
   } spbsf_flags_s;
   // A word handed over by the shift engine.
   typedef struct packed {
      logic put;
      logic [31:0] data;
   } spbsf_rxin_s;
endpackage

/* rtl/spbsf_status_flags.sv */
// Buffer status flags of a synchronous serial port, with its holding buffers and APB slave.
// Assumes one clock; the shift engine sits outside and pulses its take and put strobes.
// Behaviour
// RULE1 - transmit-empty flag, bit 3, sets when the shifter takes the transmit word
// RULE2 - transmit-empty flag clears when the core writes the data window
// RULE3 - single-entry mode: transmit-full flag, bit 1, sets on a data window write
// RULE4 - single-entry mode: transmit-full flag clears when the shifter takes the word
// RULE5 - FIFO mode: transmit-full is high exactly when write pointer plus one equals read pointer
// RULE6 - single-entry mode: receive-full flag, bit 0, sets when the shifter delivers a word
// RULE7 - single-entry mode: receive-full flag clears when the core reads the data window
// RULE8 - FIFO mode: receive-full is high exactly when shifter pointer plus one equals core pointer
// RULE9 - status bit 2 always reads zero
// RULE10 - software writes to the status word never change the three buffer flags
`include "spbsf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module spbsf_status_flags #(
   parameter int AW = 2
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire spbsf_pkg::spbsf_rxin_s shRx,
   input wire logic shTxTake,
   output logic [31:0] shTxData,
   output logic shTxValid,
   output logic irq
);
   // Holding buffers; single-entry mode only ever touches slot 0.
   logic [31:0] txMem [2**AW];
   logic [31:0] rxMem [2**AW];
   // Transmit side pointers: the core writes, the shifter reads.
   logic [AW-1:0] core_write_pointer_q;
   logic [AW-1:0] core_write_pointer_d;
   logic [AW-1:0] shifter_read_pointer_q;
   logic [AW-1:0] shifter_read_pointer_d;
   // Receive side pointers: the shifter writes, the core reads.
   logic [AW-1:0] shifter_write_pointer_q;
   logic [AW-1:0] shifter_write_pointer_d;
   logic [AW-1:0] core_read_pointer_q;
   logic [AW-1:0] core_read_pointer_d;
   // Status flags and the buffer mode.
   spbsf_pkg::spbsf_flags_s flags_q;
   spbsf_pkg::spbsf_flags_s flags_d;
   logic fifoMode_q;
   logic fifoMode_d;
   // Interrupt status, mask and the events that feed them.
   logic [`SPBSF_INT_W-1:0] istat_q;
   logic [`SPBSF_INT_W-1:0] istat_d;
   logic [`SPBSF_INT_W-1:0] imask_q;
   logic [`SPBSF_INT_W-1:0] imask_d;
   logic [`SPBSF_INT_W-1:0] events;
   // Next values of the registered outputs, and the registered pready.
   logic [31:0] prdata_d;
   logic [31:0] shTxData_d;
   logic pready_d;
   logic pslverr_d;
   logic irq_d;
   logic pready_q;
   // Decoded bus and shifter events.
   logic apbDone;
   logic wrData;
   logic rdData;
   logic ctrlWr;
   logic txPush;
   logic txTake;
   logic rxPut;
   logic rxPop;
   logic rxEmpty;

   // Pointer step; wraps naturally, so FIFO mode holds one word less than the array.
   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      return AW'(p + 1'b1);
   endfunction

   // Events. A write to a full buffer and a put into a full buffer are dropped, never merged.
   assign apbDone = psel & penable & pready_q;
   assign wrData = apbDone & pwrite & (paddr == `SPBSF_OFS_DATA);
   assign rdData = apbDone & ~pwrite & (paddr == `SPBSF_OFS_DATA);
   assign ctrlWr = apbDone & pwrite & (paddr == `SPBSF_OFS_CTRL);
   assign rxEmpty = fifoMode_q ? (shifter_write_pointer_q == core_read_pointer_q) : ~flags_q.rxFull;
   assign txPush = wrData & ~flags_q.txFull;
   assign txTake = shTxTake & ~flags_q.txEmpty;
   assign rxPut = shRx.put & ~flags_q.rxFull;
   assign rxPop = rdData & ~rxEmpty;
   assign events = {shRx.put & flags_q.rxFull, txTake, rxPut};

   // Pointers and flags. A mode change empties both buffers so the pointers start coherent.
   always_comb begin
      fifoMode_d = fifoMode_q;
      core_write_pointer_d = core_write_pointer_q;
      shifter_read_pointer_d = shifter_read_pointer_q;
      shifter_write_pointer_d = shifter_write_pointer_q;
      core_read_pointer_d = core_read_pointer_q;
      flags_d = flags_q;
      flags_d.unused = 1'b0; // RULE9
      if (ctrlWr) begin
         fifoMode_d = pwdata[`SPBSF_BIT_CTRL_FIFO];
         core_write_pointer_d = '0;
         shifter_read_pointer_d = '0;
         shifter_write_pointer_d = '0;
         core_read_pointer_d = '0;
         flags_d = `SPBSF_RST_FLAGS;
      end else if (fifoMode_q) begin
         if (txPush) core_write_pointer_d = inc(core_write_pointer_q);
         if (txTake) shifter_read_pointer_d = inc(shifter_read_pointer_q);
         if (rxPut) shifter_write_pointer_d = inc(shifter_write_pointer_q);
         if (rxPop) core_read_pointer_d = inc(core_read_pointer_q);
         flags_d.txEmpty = (core_write_pointer_d == shifter_read_pointer_d); // RULE1 RULE2
         flags_d.txFull = (inc(core_write_pointer_d) == shifter_read_pointer_d); // RULE5
         flags_d.rxFull = (inc(shifter_write_pointer_d) == core_read_pointer_d); // RULE8
      end else begin
         // A push in the same cycle as a take refills the buffer, so the push wins.
         if (txTake) begin
            flags_d.txEmpty = 1'b1; // RULE1
            flags_d.txFull = 1'b0; // RULE4
         end
         if (txPush) begin
            flags_d.txEmpty = 1'b0; // RULE2
            flags_d.txFull = 1'b1; // RULE3
         end
         if (rxPop) flags_d.rxFull = 1'b0; // RULE7
         if (rxPut) flags_d.rxFull = 1'b1; // RULE6
      end
   end

   // Bus answers, interrupt status and the word offered to the shifter.
   always_comb begin
      pready_d = psel & penable & ~pready_q;
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (pready_d) begin
         unique case (paddr)
            `SPBSF_OFS_STATUS: prdata_d = {28'h0000000, flags_q}; // RULE9
            `SPBSF_OFS_CTRL: prdata_d = {31'h00000000, fifoMode_q};
            `SPBSF_OFS_DATA: prdata_d = rxMem[core_read_pointer_q];
            `SPBSF_OFS_ISTAT: prdata_d = {29'h00000000, istat_q};
            `SPBSF_OFS_IMASK: prdata_d = {29'h00000000, imask_q};
            default: pslverr_d = 1'b1;
         endcase
      end
      // Set wins over a write-one clear in the same cycle.
      istat_d = istat_q;
      if (apbDone && pwrite && paddr == `SPBSF_OFS_ISTAT) begin
         istat_d = istat_q & ~pwdata[`SPBSF_INT_W-1:0];
      end
      istat_d = istat_d | events;
      imask_d = imask_q;
      if (apbDone && pwrite && paddr == `SPBSF_OFS_IMASK) begin
         imask_d = pwdata[`SPBSF_INT_W-1:0];
      end
      irq_d = |(istat_d & imask_d);
      shTxData_d = (txPush && core_write_pointer_q == shifter_read_pointer_d) ? pwdata : txMem[shifter_read_pointer_d];
   end

   // Registers. Status writes fall through here untouched; only events move the flags.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fifoMode_q <= 1'b0;
         core_write_pointer_q <= '0;
         shifter_read_pointer_q <= '0;
         shifter_write_pointer_q <= '0;
         core_read_pointer_q <= '0;
         flags_q <= `SPBSF_RST_FLAGS;
         istat_q <= `SPBSF_RST_INT;
         imask_q <= `SPBSF_RST_INT;
         irq <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         shTxData <= '0;
         shTxValid <= 1'b0;
      end else begin
         fifoMode_q <= fifoMode_d;
         core_write_pointer_q <= core_write_pointer_d;
         shifter_read_pointer_q <= shifter_read_pointer_d;
         shifter_write_pointer_q <= shifter_write_pointer_d;
         core_read_pointer_q <= core_read_pointer_d;
         flags_q <= flags_d; // RULE10
         istat_q <= istat_d;
         imask_q <= imask_d;
         irq <= irq_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         shTxData <= shTxData_d;
         shTxValid <= ~flags_d.txEmpty;
      end
   end

   // The registered answer doubles as the access-phase completion marker.
   assign pready_q = pready;

   // Buffer storage; no reset, a word is only taken or popped after its slot was written.
   always_ff @(posedge ref_clk) begin
      if (txPush) txMem[core_write_pointer_q] <= pwdata;
      if (rxPut) rxMem[shifter_write_pointer_q] <= shRx.data;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   // Checks on the transmit and receive flags. In FIFO mode only the last word's take empties the transmit buffer.
   a_tbe_set_take: assert property (txTake && !txPush && !ctrlWr
      && (!fifoMode_q || inc(shifter_read_pointer_q) == core_write_pointer_q) |=> flags_q.txEmpty) // RULE1
      else $error("transmit empty did not set after a take");
   a_tbe_clr_write: assert property (txPush && !ctrlWr |=> !flags_q.txEmpty && shTxValid) // RULE2
      else $error("transmit empty did not clear after a write");
   a_tbf_std_set: assert property (!fifoMode_q && txPush && !ctrlWr |=> flags_q.txFull) // RULE3
      else $error("single-entry transmit full did not set");
   a_tbf_std_clr: assert property (!fifoMode_q && txTake && !txPush && !ctrlWr
      |=> !flags_q.txFull ##1 (!flags_q.txFull || $past(txPush))) // RULE4
      else $error("single-entry transmit full did not clear");
   a_tbf_fifo_ptr: assert property (fifoMode_q |-> flags_q.txFull == (inc(core_write_pointer_q) == shifter_read_pointer_q)) // RULE5
      else $error("fifo transmit full disagrees with pointers");
   a_rbf_std_set: assert property (!fifoMode_q && rxPut && !ctrlWr |=> flags_q.rxFull) // RULE6
      else $error("single-entry receive full did not set");
   a_rbf_std_clr: assert property (!fifoMode_q && rxPop && !rxPut && !ctrlWr |=> !flags_q.rxFull) // RULE7
      else $error("single-entry receive full did not clear");
   a_rbf_fifo_ptr: assert property (fifoMode_q |-> flags_q.rxFull == (inc(shifter_write_pointer_q) == core_read_pointer_q)) // RULE8
      else $error("fifo receive full disagrees with pointers");
   // The status word is taken one edge before pready shows it, so compare with that edge.
   a_status_bit2_zero: assert property (pready && !pwrite && paddr == `SPBSF_OFS_STATUS
      |-> !prdata[2] && prdata[3] == $past(flags_q.txEmpty)) // RULE9
      else $error("status bit 2 read as one");
   a_flags_sw_hold: assert property (apbDone && pwrite && paddr == `SPBSF_OFS_STATUS
      && !txPush && !txTake && !rxPut && !rxPop |=> $stable(flags_q)) // RULE10
      else $error("status write changed a flag");
   // The FIFO empty flag must track the transmit pointers at all times.
   a_fifo_tx_empty: assert property (fifoMode_q |-> flags_q.txEmpty == (core_write_pointer_q == shifter_read_pointer_q)) // RULE1
      else $error("fifo transmit empty disagrees with pointers");
   // Single-entry mode keeps both core pointers parked on slot 0.
   a_single_slot: assert property (!fifoMode_q |-> core_write_pointer_q == '0 && core_read_pointer_q == '0) // RULE3
      else $error("single-entry mode moved a pointer");
   // A mode write leaves both buffers empty with coherent pointers.
   a_mode_write_empty: assert property (ctrlWr
      |=> flags_q == `SPBSF_RST_FLAGS && core_write_pointer_q == shifter_read_pointer_q) // RULE10
      else $error("mode write did not empty the buffers");
   // Refused traffic must not move any pointer.
   a_tx_full_drop: assert property (wrData && flags_q.txFull |=> $stable(core_write_pointer_q)) // RULE5
      else $error("write to a full transmit buffer moved the pointer");
   a_rx_full_drop: assert property (shRx.put && flags_q.rxFull && !ctrlWr
      |=> $stable(shifter_write_pointer_q)) // RULE8
      else $error("put into a full receive buffer moved the pointer");
   a_rx_empty_nopop: assert property (rdData && rxEmpty |=> $stable(core_read_pointer_q)) // RULE7
      else $error("read of an empty receive buffer popped");
   // The valid level offered to the shifter is the inverse of the empty flag.
   a_valid_mirror: assert property (shTxValid == !flags_q.txEmpty) // RULE1
      else $error("transmit valid disagrees with the empty flag");
   // Bus answer shape: one wait state, a one-cycle pulse, and idle data at zero.
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready did not follow the first access cycle");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready stood for more than one cycle");
   a_prdata_idle: assert property (!pready |-> prdata == '0)
      else $error("read data not zero outside an answer");
   a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {`SPBSF_OFS_STATUS,
      `SPBSF_OFS_CTRL, `SPBSF_OFS_DATA, `SPBSF_OFS_ISTAT, `SPBSF_OFS_IMASK}))
      else $error("slave error disagrees with the address map");
   // An event wins over a clear written in the same cycle.
   a_istat_set_wins: assert property (|events
      |=> (istat_q & $past(events)) == $past(events))
      else $error("interrupt status lost an event");
   // The interrupt is a plain level of the registered status and mask.
   a_irq_level: assert property (irq == |(istat_q & imask_q))
      else $error("interrupt level disagrees with status and mask");

   c_std_tx_cycle: cover property (!fifoMode_q && txPush ##[1:20] txTake);
   c_fifo_tx_full: cover property (fifoMode_q && flags_q.txFull);
   c_fifo_rx_full: cover property (fifoMode_q && flags_q.rxFull ##[1:20] rxPop);
   c_irq_raised: cover property ($rose(irq));
   c_slverr_seen: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* test/spbsf_shifter_model.sv */
// Shift engine model: takes transmit words and delivers received words on command.
// Assumes the bench calls its tasks; strobes last one clock, as the shifter side expects.
`timescale 1ns/1ps
`default_nettype none
module spbsf_shifter_model (
   input wire logic ref_clk,
   output var spbsf_pkg::spbsf_rxin_s shRx,
   output logic shTxTake
);
   initial begin
      shRx = '0;
      shTxTake = 1'h0;
   end
   // Pulse the take strobe for one cycle.
   task automatic take();
      @(posedge ref_clk) shTxTake <= 1'h1;
      @(posedge ref_clk) shTxTake <= 1'h0;
   endtask
   // Deliver one word; afterwards the data lines show the inverse so a stale value never passes.
   task automatic put(input logic [31:0] w);
      @(posedge ref_clk) shRx <= '{put: 1'h1, data: w};
      @(posedge ref_clk) shRx <= '{put: 1'h0, data: ~w};
   endtask
endmodule
`default_nettype wire

/* test/serial_port_buffer_status_flags_tb_top.sv */
// Bench for the serial port status flags: row-driven APB and shifter traffic.
// Assumes the package and the shifter model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module serial_port_buffer_status_flags_tb_top;
   typedef struct packed {logic [1:0] op; logic [7:0] a; logic [31:0] d; logic [31:0] e;} spbsf_row_s;
   logic ref_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, shTxData;
   logic pready, pslverr, shTxTake, shTxValid, irq, er;
   spbsf_pkg::spbsf_rxin_s shRx;
   int errors = 0, num_checks = 0, cyc = 0;
   // Op 0 writes, 1 reads and compares, 2 makes the shifter take, 3 delivers d.
   spbsf_row_s rows [28] = '{
      '{2'h0, 8'h00, 32'hF, 32'h0}, '{2'h1, 8'h00, 32'h0, 32'h8},
      '{2'h0, 8'h10, 32'h7, 32'h0}, '{2'h0, 8'h08, 32'hA5, 32'h0},
      '{2'h1, 8'h00, 32'h0, 32'h2}, '{2'h2, 8'h00, 32'h0, 32'h0},
      '{2'h1, 8'h00, 32'h0, 32'h8}, '{2'h3, 8'h00, 32'h5A, 32'h0},
      '{2'h1, 8'h00, 32'h0, 32'h9}, '{2'h1, 8'h08, 32'h0, 32'h5A},
      '{2'h1, 8'h00, 32'h0, 32'h8}, '{2'h1, 8'h0C, 32'h0, 32'h3},
      '{2'h0, 8'h0C, 32'h3, 32'h0}, '{2'h1, 8'h0C, 32'h0, 32'h0},
      '{2'h0, 8'h04, 32'h1, 32'h0}, '{2'h0, 8'h08, 32'h1, 32'h0},
      '{2'h0, 8'h08, 32'h2, 32'h0}, '{2'h1, 8'h00, 32'h0, 32'h0},
      '{2'h0, 8'h08, 32'h3, 32'h0}, '{2'h1, 8'h00, 32'h0, 32'h2},
      '{2'h2, 8'h00, 32'h0, 32'h0}, '{2'h1, 8'h00, 32'h0, 32'h0},
      '{2'h3, 8'h00, 32'h11, 32'h0}, '{2'h3, 8'h00, 32'h22, 32'h0},
      '{2'h1, 8'h00, 32'h0, 32'h0}, '{2'h3, 8'h00, 32'h33, 32'h0},
      '{2'h1, 8'h00, 32'h0, 32'h1}, '{2'h1, 8'h08, 32'h0, 32'h11}};
   spbsf_status_flags #(.AW(2)) spbsf_status_flags_i (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .shRx(shRx), .shTxTake(shTxTake),
      .shTxData(shTxData), .shTxValid(shTxValid), .irq(irq));
   spbsf_shifter_model spbsf_shifter_model_i (.ref_clk(ref_clk), .shRx(shRx),
      .shTxTake(shTxTake));
   // Free-running 250 MHz clock.
   always #2 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // A hung handshake would stall forever, so a cycle ceiling ends the run.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
         begin errors++; $display("ERROR %s expected %h seen %h", n, e, g); end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do @(posedge ref_clk); while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Table pass first, then interrupt, refusal and reset cases by hand.
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'h1;
      foreach (rows[i]) begin
         case (rows[i].op)
            2'h0: apb(1'h1, rows[i].a, rows[i].d, rd, er);
            2'h1: begin
               apb(1'h0, rows[i].a, 32'h0, rd, er);
               chk("read", rows[i].e, rd);
            end
            2'h2: spbsf_shifter_model_i.take();
            default: spbsf_shifter_model_i.put(rows[i].d);
         endcase
      end
      repeat (2) @(posedge ref_clk);
      chkb("irq", 1'h1, irq);
      apb(1'h1, 8'h10, 32'h0, rd, er);
      repeat (2) @(posedge ref_clk);
      chkb("irq masked", 1'h0, irq);
      chkb("tx valid", 1'h1, shTxValid);
      chk("tx head", 32'h2, shTxData);
      apb(1'h0, 8'h20, 32'h0, rd, er);
      chkb("slverr", 1'h1, er);
      apb(1'h1, 8'h00, 32'hF, rd, er);
      apb(1'h0, 8'h00, 32'h0, rd, er);
      chk("status", 32'h0, rd);
      nrst <= 1'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'h1;
      apb(1'h0, 8'h00, 32'h0, rd, er);
      chk("status reset", 32'h8, rd);
      chkb("valid reset", 1'h0, shTxValid);
      end_of_test();
   end
endmodule
`default_nettype wire
